// *** design/isp_consts.vh ***
// Constants for the serial in-system programming host
// Overview of operation
// - Programming only while device reset is low, over clock, data-in and data-out pins.
// - After reset goes low, enable instruction goes first; nothing else before acceptance.
// - Each clock phase longer than 2 device cycles, or 3 at 12 MHz up.
// - Power-up with reset and clock low, then a reset pulse of two cycles.
// - Wait at least 20 ms after power-up before the enable instruction.
// - Device echoes 0x53 during third byte; all four bytes are always sent.
// - Missing echo: pulse reset high, then send a fresh enable instruction.
// - Flash written by page; loads pick the word by 6 low address bits.
// - For each flash word, load the low byte before the high byte.
// - Without polling, wait 4.5 ms after a flash page write.
// - Byte EEPROM write self-erases; without polling wait 9.0 ms after it.
// - EEPROM page loads use 2 low bits; page write uses 8 upper bits.
// - Releasing reset high ends programming and starts normal operation.
// - Without polling, wait 4.5 ms after fuse write, 9.0 ms after erase.
// - Busy poll byte bit 0 is 1 while busy; wait until it reads 0.
`ifndef ISP_CONSTS_VH
`define ISP_CONSTS_VH

// Clock rates
`define CLK_MHZ 32'd40
`define CLK_KHZ 32'd40000

// Wait times in microseconds
`define T_PWRUP_US 32'd20000
`define T_WD_FUSE_US 32'd4500
`define T_WD_FLASH_US 32'd4500
`define T_WD_EEPROM_US 32'd9000
`define T_WD_ERASE_US 32'd9000

// Least device clock cycles per serial clock phase, and per reset pulse
`define DEV_PHASE_CYC 32'd3
`define DEV_PULSE_CYC 32'd2

// Frame layout
`define FRAME_BITS 6'h20
`define BUSY_BIT 0

// Instruction bytes
`define I_PE 8'hac
`define I_PE_KEY 8'h53
`define I_ERASE 8'h80
`define I_POLL 8'hf0
`define I_LD_HI 8'h48
`define I_LD_LO 8'h40
`define I_LD_EE 8'hc1
`define I_RD_HI 8'h28
`define I_RD_LO 8'h20
`define I_RD_EE 8'ha0
`define I_RD_SIG 8'h30
`define I_RD_FUSE 8'h50
`define I_RD_LOCK 8'h58
`define I_WR_PAGE 8'h4c
`define I_WR_EE 8'hc0
`define I_WR_EE_PG 8'hc2
`define I_WR_LOCK 8'he0
`define I_WR_FUSE 8'ha0

// User command codes
`define OP_ERASE 4'h0
`define OP_POLL 4'h1
`define OP_LD_LO 4'h2
`define OP_LD_HI 4'h3
`define OP_LD_EE 4'h4
`define OP_RD_LO 4'h5
`define OP_RD_HI 4'h6
`define OP_RD_EE 4'h7
`define OP_WR_PAGE 4'h8
`define OP_WR_EE 4'h9
`define OP_WR_EE_PG 4'ha
`define OP_RD_SIG 4'hb
`define OP_RD_FUSE 4'hc
`define OP_WR_FUSE 4'hd
`define OP_RD_LOCK 4'he
`define OP_WR_LOCK 4'hf

`endif

// *** design/isp_sync2.v ***
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/10ps
module isp_sync2 (
  input wire clk_sys,
  input wire rst_b,
  input wire d_in,
  output wire q_out
);
  reg meta_ff;
  reg sync_ff;

  // First flop feeds only the second
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= d_in;
      sync_ff <= meta_ff;
    end
  end

  assign q_out = sync_ff;
endmodule // isp_sync2

// *** design/isp_fifo2.v ***
// Small buffer with valid and ready on both sides
`timescale 1ns/10ps
module isp_fifo2 #(
  parameter WIDTH = 8,
  parameter DEPTH = 2,
  parameter AW = 1
) (
  input wire clk_sys,
  input wire rst_b,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  wire do_wr;
  wire do_rd;

  // Honest full and empty from the occupancy count
  assign in_ready = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign do_wr = in_valid & in_ready;
  assign do_rd = out_valid & out_ready;
  assign out_data = mem_ff[rd_ptr_ff];

  // Pointer and count upkeep
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count_ff <= count_ff + 1'b1;
      end else if (do_rd && !do_wr) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

  // Storage, one entry per slot
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_slot
      always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          mem_ff[i] <= {WIDTH{1'b0}};
        end else if (do_wr && wr_ptr_ff == i) begin
          mem_ff[i] <= in_data;
        end
      end
    end
  endgenerate
endmodule // isp_fifo2

// *** design/isp_host.v ***
// Serial programming host: drives device reset, serial clock and data pins
`include "isp_consts.vh"
`timescale 1ns/10ps
module isp_host #(
  parameter [31:0] DEV_KHZ = 32'd8000,
  parameter [31:0] PWRUP_CYC = `T_PWRUP_US * `CLK_MHZ,
  parameter [31:0] WD_SHORT_CYC = `T_WD_FLASH_US * `CLK_MHZ,
  parameter [31:0] WD_LONG_CYC = `T_WD_EEPROM_US * `CLK_MHZ,
  parameter [3:0] MAX_RETRY = 4'h8,
  parameter RSP_DEPTH = 2,
  parameter RSP_AW = 1
) (
  input wire clk_sys,
  input wire rst_b,
  input wire session_en,
  input wire use_poll,
  input wire cmd_valid,
  output wire cmd_ready,
  input wire [3:0] cmd_op,
  input wire [15:0] cmd_addr,
  input wire [7:0] cmd_data,
  output reg cmd_err_ff,
  output wire rsp_valid,
  input wire rsp_ready,
  output wire [7:0] rsp_data,
  output reg prog_enabled_ff,
  output reg sync_err_ff,
  output wire busy,
  output reg dev_rst_b_ff,
  output reg sck_ff,
  output reg mosi_ff,
  input wire miso
);
  // Serial clock half period: strictly above three device cycles
  localparam [31:0] HALF_CYC = (`DEV_PHASE_CYC * `CLK_KHZ) / DEV_KHZ + 32'd1;
  localparam [31:0] PULSE_CYC = (`DEV_PULSE_CYC * `CLK_KHZ) / DEV_KHZ + 32'd1;

  // One-hot states
  localparam [7:0] S_OFF = 8'h01;
  localparam [7:0] S_PREP = 8'h02;
  localparam [7:0] S_PULSE = 8'h04;
  localparam [7:0] S_SETTLE = 8'h08;
  localparam [7:0] S_IDLE = 8'h10;
  localparam [7:0] S_SHIFT = 8'h20;
  localparam [7:0] S_DONE = 8'h40;
  localparam [7:0] S_WAIT = 8'h80;

  // Frame kinds
  localparam [1:0] K_PE = 2'd0;
  localparam [1:0] K_USER = 2'd1;
  localparam [1:0] K_POLL = 2'd2;

  // Wait classes after a write
  localparam [1:0] W_NONE = 2'd0;
  localparam [1:0] W_SHORT = 2'd1;
  localparam [1:0] W_LONG = 2'd2;

  reg [7:0] state_ff;
  reg [1:0] kind_ff;
  reg [15:0] hcnt_ff;
  reg [5:0] bcnt_ff;
  reg [31:0] tx_ff;
  reg [31:0] rx_ff;
  reg [23:0] wcnt_ff;
  reg [3:0] retry_ff;
  reg rd_ff;
  reg [1:0] wait_ff;
  reg lo_vld_ff;
  reg [5:0] lo_addr_ff;
  reg push_ff;
  reg [7:0] push_data_ff;
  reg [31:0] frame;
  reg is_read;
  reg [1:0] wait_kind;
  reg order_bad;
  wire miso_s;
  wire buf_in_ready;
  wire take;

  // Data-out pin is asynchronous to clk_sys
  isp_sync2 u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .d_in(miso),
    .q_out(miso_s)
  );

  // Read results queue; a stalled consumer holds off new reads
  isp_fifo2 #(
    .WIDTH(8),
    .DEPTH(RSP_DEPTH),
    .AW(RSP_AW)
  ) u_rsp (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .in_valid(push_ff),
    .in_ready(buf_in_ready),
    .in_data(push_data_ff),
    .out_valid(rsp_valid),
    .out_ready(rsp_ready),
    .out_data(rsp_data)
  );

  // Build the four-byte frame for the user command
  always @* begin
    frame = 32'h0;
    is_read = 1'b0;
    wait_kind = W_NONE;
    order_bad = 1'b0;
    case (cmd_op)
      `OP_ERASE: begin
        frame = {`I_PE, `I_ERASE, 16'h0};
        wait_kind = W_LONG;
      end
      `OP_POLL: begin
        frame = {`I_POLL, 24'h0};
        is_read = 1'b1;
      end
      `OP_LD_LO: begin
        frame = {`I_LD_LO, 8'h0, 2'b00, cmd_addr[5:0], cmd_data};
      end
      `OP_LD_HI: begin
        frame = {`I_LD_HI, 8'h0, 2'b00, cmd_addr[5:0], cmd_data};
        order_bad = ~lo_vld_ff | (lo_addr_ff != cmd_addr[5:0]);
      end
      `OP_LD_EE: begin
        frame = {`I_LD_EE, 8'h0, 6'h0, cmd_addr[1:0], cmd_data};
      end
      `OP_RD_LO: begin
        frame = {`I_RD_LO, cmd_addr, 8'h0};
        is_read = 1'b1;
      end
      `OP_RD_HI: begin
        frame = {`I_RD_HI, cmd_addr, 8'h0};
        is_read = 1'b1;
      end
      `OP_RD_EE: begin
        frame = {`I_RD_EE, 6'h0, cmd_addr[9:0], 8'h0};
        is_read = 1'b1;
      end
      `OP_WR_PAGE: begin
        frame = {`I_WR_PAGE, cmd_addr, 8'h0};
        wait_kind = W_SHORT;
      end
      `OP_WR_EE: begin
        frame = {`I_WR_EE, 6'h0, cmd_addr[9:0], cmd_data};
        wait_kind = W_LONG;
      end
      `OP_WR_EE_PG: begin
        frame = {`I_WR_EE_PG, 6'h0, cmd_addr[9:2], 2'b00, 8'h0};
        wait_kind = W_LONG;
      end
      `OP_RD_SIG: begin
        frame = {`I_RD_SIG, 8'h0, 6'h0, cmd_addr[1:0], 8'h0};
        is_read = 1'b1;
      end
      `OP_RD_FUSE: begin
        frame = {`I_RD_FUSE, 8'h0, 16'h0};
        is_read = 1'b1;
      end
      `OP_WR_FUSE: begin
        frame = {`I_PE, `I_WR_FUSE, 8'h0, cmd_data};
        wait_kind = W_SHORT;
      end
      `OP_RD_LOCK: begin
        frame = {`I_RD_LOCK, 8'h0, 16'h0};
        is_read = 1'b1;
      end
      default: begin
        frame = {`I_PE, `I_WR_LOCK, 8'h0, cmd_data};
        wait_kind = W_SHORT;
      end
    endcase
  end

  // Commands only in idle; reads need room, counting an answer still on its way in
  assign cmd_ready = (state_ff == S_IDLE) & (~is_read | (buf_in_ready & ~push_ff));
  assign take = cmd_valid & cmd_ready;
  assign busy = (state_ff != S_IDLE) & (state_ff != S_OFF);

  // Load a frame into the shifter with the clock low
  task start_frame;
    input [31:0] f;
    input [1:0] k;
    begin
      tx_ff <= f;
      mosi_ff <= f[31];
      bcnt_ff <= 6'h0;
      hcnt_ff <= HALF_CYC[15:0] - 16'h1;
      sck_ff <= 1'b0;
      kind_ff <= k;
      state_ff <= S_SHIFT;
    end
  endtask

  // Session sequencer and serial shifter
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= S_OFF;
      kind_ff <= K_PE;
      hcnt_ff <= 16'h0;
      bcnt_ff <= 6'h0;
      tx_ff <= 32'h0;
      rx_ff <= 32'h0;
      wcnt_ff <= 24'h0;
      retry_ff <= 4'h0;
      rd_ff <= 1'b0;
      wait_ff <= W_NONE;
      lo_vld_ff <= 1'b0;
      lo_addr_ff <= 6'h0;
      push_ff <= 1'b0;
      push_data_ff <= 8'h0;
      cmd_err_ff <= 1'b0;
      prog_enabled_ff <= 1'b0;
      sync_err_ff <= 1'b0;
      dev_rst_b_ff <= 1'b1;
      sck_ff <= 1'b0;
      mosi_ff <= 1'b0;
    end else begin
      push_ff <= 1'b0;
      cmd_err_ff <= 1'b0;
      if (!session_en && state_ff != S_OFF) begin
        // Release reset: device leaves programming and runs
        dev_rst_b_ff <= 1'b1;
        sck_ff <= 1'b0;
        mosi_ff <= 1'b0;
        prog_enabled_ff <= 1'b0;
        lo_vld_ff <= 1'b0;
        state_ff <= S_OFF;
      end else begin
        case (state_ff)
          S_OFF: begin
            if (session_en) begin
              dev_rst_b_ff <= 1'b0;
              sck_ff <= 1'b0;
              sync_err_ff <= 1'b0;
              retry_ff <= 4'h0;
              wcnt_ff <= PULSE_CYC[23:0];
              state_ff <= S_PREP;
            end
          end
          S_PREP: begin
            // Clock is low; now give reset a positive pulse
            if (wcnt_ff == 24'h0) begin
              dev_rst_b_ff <= 1'b1;
              wcnt_ff <= PULSE_CYC[23:0];
              state_ff <= S_PULSE;
            end else begin
              wcnt_ff <= wcnt_ff - 24'h1;
            end
          end
          S_PULSE: begin
            if (wcnt_ff == 24'h0) begin
              dev_rst_b_ff <= 1'b0;
              prog_enabled_ff <= 1'b0;
              wcnt_ff <= PWRUP_CYC[23:0];
              state_ff <= S_SETTLE;
            end else begin
              wcnt_ff <= wcnt_ff - 24'h1;
            end
          end
          S_SETTLE: begin
            if (wcnt_ff == 24'h0) begin
              start_frame({`I_PE, `I_PE_KEY, 16'h0}, K_PE);
            end else begin
              wcnt_ff <= wcnt_ff - 24'h1;
            end
          end
          S_IDLE: begin
            if (take) begin
              if (!prog_enabled_ff || (cmd_op == `OP_LD_HI && order_bad)) begin
                cmd_err_ff <= 1'b1;
              end else begin
                if (cmd_op == `OP_LD_LO) begin
                  lo_vld_ff <= 1'b1;
                  lo_addr_ff <= cmd_addr[5:0];
                end else if (cmd_op == `OP_LD_HI || cmd_op == `OP_WR_PAGE) begin
                  lo_vld_ff <= 1'b0;
                end
                rd_ff <= is_read;
                wait_ff <= wait_kind;
                start_frame(frame, K_USER);
              end
            end
          end
          S_SHIFT: begin
            if (hcnt_ff != 16'h0) begin
              hcnt_ff <= hcnt_ff - 16'h1;
            end else if (!sck_ff) begin
              sck_ff <= 1'b1;
              hcnt_ff <= HALF_CYC[15:0] - 16'h1;
            end else begin
              // Sample before the falling edge; device changes after it
              sck_ff <= 1'b0;
              rx_ff <= {rx_ff[30:0], miso_s};
              tx_ff <= {tx_ff[30:0], 1'b0};
              mosi_ff <= tx_ff[30];
              hcnt_ff <= HALF_CYC[15:0] - 16'h1;
              if (bcnt_ff == `FRAME_BITS - 6'h1) begin
                state_ff <= S_DONE;
              end else begin
                bcnt_ff <= bcnt_ff + 6'h1;
              end
            end
          end
          S_DONE: begin
            mosi_ff <= 1'b0;
            case (kind_ff)
              K_PE: begin
                if (rx_ff[15:8] == `I_PE_KEY) begin
                  prog_enabled_ff <= 1'b1;
                  state_ff <= S_IDLE;
                end else if (retry_ff == MAX_RETRY) begin
                  sync_err_ff <= 1'b1;
                  state_ff <= S_IDLE;
                end else begin
                  retry_ff <= retry_ff + 4'h1;
                  dev_rst_b_ff <= 1'b1;
                  wcnt_ff <= PULSE_CYC[23:0];
                  state_ff <= S_PULSE;
                end
              end
              K_POLL: begin
                if (rx_ff[`BUSY_BIT]) begin
                  start_frame({`I_POLL, 24'h0}, K_POLL);
                end else begin
                  state_ff <= S_IDLE;
                end
              end
              default: begin
                if (rd_ff) begin
                  push_ff <= 1'b1;
                  push_data_ff <= rx_ff[7:0];
                end
                if (wait_ff == W_NONE) begin
                  state_ff <= S_IDLE;
                end else if (use_poll) begin
                  start_frame({`I_POLL, 24'h0}, K_POLL);
                end else begin
                  wcnt_ff <= (wait_ff == W_LONG) ? WD_LONG_CYC[23:0] : WD_SHORT_CYC[23:0];
                  state_ff <= S_WAIT;
                end
              end
            endcase
          end
          S_WAIT: begin
            if (wcnt_ff == 24'h0) begin
              state_ff <= S_IDLE;
            end else begin
              wcnt_ff <= wcnt_ff - 24'h1;
            end
          end
          default: begin
            state_ff <= S_OFF;
          end
        endcase
      end
    end
  end
endmodule // isp_host

// *** tb/isp_dev_model.sv ***
// Behavioural model of the programmed device on the serial link
`timescale 1ns/10ps
module isp_dev_model #(
  parameter int T_SHORT_NS = 40000,
  parameter int T_LONG_NS = 60000,
  parameter logic [7:0] SIG_BASE = 8'h5c // Arbitrary identity value
) (
  input wire logic dev_rst_b,
  input wire logic sck,
  input wire logic mosi,
  input wire logic bad_echo,
  output logic miso = 1'b0,
  output logic in_prog = 1'b0,
  output int viol = 0,
  output int n_pe = 0
);
  logic [31:0] rx = 32'h0;
  logic [7:0] tx = 8'h00, fuse = 8'hff, lock = 8'hff;
  logic [7:0] fl[int], ee[int], pb[int], epb[int];
  bit lo_ok [64];
  int nb = 0;
  time busy_end = 0;
  // Unwritten cells read as erased
  function automatic logic [7:0] rd_byte(ref logic [7:0] m[int], input int k);
    return m.exists(k) ? m[k] : 8'hff;
  endfunction
  // Answer byte, chosen once bytes one to three are in
  function automatic logic [7:0] rd_data(logic [23:0] h);
    case (h[23:16])
      8'hf0: return {7'h00, $time < busy_end};
      8'h20: return rd_byte(fl, {h[15:0], 1'b0});
      8'h28: return rd_byte(fl, {h[15:0], 1'b1});
      8'ha0: return rd_byte(ee, h[9:0]);
      8'h30: return SIG_BASE + {6'h00, h[1:0]};
      8'h50: return fuse;
      8'h58: return lock;
      default: return 8'h00;
    endcase
  endfunction
  // Frame decode once all 32 bits are in
  task automatic run(logic [31:0] f);
    if (f[31:16] == 16'hac53) begin
      n_pe++;
      in_prog = !bad_echo;
    end else if (in_prog) begin
      case (f[31:24])
        8'hac: begin
          if (f[23:16] == 8'h80) begin
            fl.delete();
            ee.delete();
            lock = 8'hff;
            busy_end = $time + T_LONG_NS;
          end
          if (f[23:16] == 8'ha0) fuse = f[7:0];
          if (f[23:16] == 8'he0) lock = f[7:0];
          if (f[23:16] != 8'h80) busy_end = $time + T_SHORT_NS;
        end
        8'h40: begin
          pb[{f[13:8], 1'b0}] = f[7:0];
          lo_ok[f[13:8]] = 1'b1;
        end
        8'h48: begin
          if (!lo_ok[f[13:8]]) viol++;
          pb[{f[13:8], 1'b1}] = f[7:0];
          lo_ok[f[13:8]] = 1'b0;
        end
        8'h4c: begin
          foreach (pb[k]) fl[{f[23:14], k[6:0]}] = pb[k];
          pb.delete();
          busy_end = $time + T_SHORT_NS;
        end
        8'hc0: begin
          ee[f[17:8]] = f[7:0];
          busy_end = $time + T_LONG_NS;
        end
        8'hc1: epb[f[9:8]] = f[7:0];
        8'hc2: begin
          foreach (epb[k]) ee[{f[17:10], k[1:0]}] = epb[k];
          epb.delete();
          busy_end = $time + T_LONG_NS;
        end
        default: ;
      endcase
    end
  endtask
  // Shift in on the rising clock edge, only while held in reset
  always @(posedge sck) begin
    if (!dev_rst_b) begin
      rx = {rx[30:0], mosi};
      nb++;
      // Anything but a poll started while a write is pending is misuse
      if (nb == 8 && in_prog && rx[7:0] != 8'hf0 && $time < busy_end) viol++;
      if (nb == 16) tx = bad_echo ? ~rx[7:0] : rx[7:0];
      if (nb == 24) tx = rd_data(rx[23:0]);
      if (nb == 32) begin
        nb = 0;
        run(rx);
      end
    end
  end
  // Shift out on the falling clock edge
  always @(negedge sck) begin
    if (!dev_rst_b) begin
      miso = tx[7];
      tx = {tx[6:0], ~tx[0]};
    end
  end
  // Release ends the session; the output no longer shows its last level
  always @(posedge dev_rst_b) begin
    in_prog = 1'b0;
    nb = 0;
    miso = ~miso;
  end
endmodule // isp_dev_model

// *** tb/isp_host_props.sv ***
// Concurrent checks on the ports of the programming host
`timescale 1ns/10ps
`include "isp_consts.vh"
module isp_host_props #(
  parameter [31:0] DEV_KHZ = 32'd8000
) (
  input logic clk_sys,
  input logic rst_b,
  input logic session_en,
  input logic cmd_valid,
  input logic cmd_ready,
  input logic [3:0] cmd_op,
  input logic cmd_err_ff,
  input logic rsp_valid,
  input logic rsp_ready,
  input logic [7:0] rsp_data,
  input logic prog_enabled_ff,
  input logic sync_err_ff,
  input logic busy,
  input logic dev_rst_b_ff,
  input logic sck_ff,
  input logic mosi_ff
);
  localparam [31:0] MIN_PH = (`DEV_PHASE_CYC * `CLK_KHZ + DEV_KHZ - 1) / DEV_KHZ;
  logic sck_d_ff;
  logic [7:0] ph_cnt_ff;
  wire [7:0] nxt_ph_cnt = (sck_ff != sck_d_ff) ? 8'h01 :
    ((ph_cnt_ff == 8'hff) ? 8'hff : ph_cnt_ff + 8'h01);
  // Length of the serial clock phase that just ended
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sck_d_ff <= 1'b0;
      ph_cnt_ff <= 8'hff;
    end else begin
      sck_d_ff <= sck_ff;
      ph_cnt_ff <= nxt_ph_cnt;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_idle_when_off: assert property (!session_en [*3] |-> dev_rst_b_ff && !sck_ff)
    else $error("device reset or clock active outside a session");
  a_clock_in_rst: assert property (sck_ff |-> !dev_rst_b_ff)
    else $error("serial clock high while device reset released");
  a_phase_long: assert property ((sck_ff != sck_d_ff) && session_en |-> ph_cnt_ff >= MIN_PH[7:0])
    else $error("serial clock phase too short");
  a_data_held: assert property (sck_ff |-> $stable(mosi_ff))
    else $error("serial data moved while clock high");
  a_refuse_early: assert property (cmd_valid && cmd_ready && !prog_enabled_ff |=> cmd_err_ff)
    else $error("command not refused before enable");
  a_take_frame: assert property (cmd_valid && cmd_ready && prog_enabled_ff
    && cmd_op != `OP_LD_HI |=> busy && !sck_ff && !cmd_err_ff)
    else $error("accepted command did not start a frame");
  a_rsp_held: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
    else $error("response dropped or changed before taken");
  a_ready_idle: assert property (cmd_ready |-> !busy)
    else $error("command ready while busy");
  a_enable_in_rst: assert property ($rose(prog_enabled_ff) |-> !dev_rst_b_ff)
    else $error("enable seen while device reset released");
  a_pulse_len: assert property ($rose(dev_rst_b_ff) && session_en |-> dev_rst_b_ff [*5])
    else $error("device reset pulse too short");
  c_enabled: cover property ($rose(prog_enabled_ff));
  c_refused: cover property (cmd_err_ff);
  c_stalled: cover property (rsp_valid && !rsp_ready && !cmd_ready);
  c_sync_fail: cover property ($rose(sync_err_ff));
endmodule // isp_host_props
bind isp_host isp_host_props #(.DEV_KHZ(DEV_KHZ)) u_props (.clk_sys(clk_sys), .rst_b(rst_b),
  .session_en(session_en), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
  .cmd_err_ff(cmd_err_ff), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data),
  .prog_enabled_ff(prog_enabled_ff), .sync_err_ff(sync_err_ff), .busy(busy),
  .dev_rst_b_ff(dev_rst_b_ff), .sck_ff(sck_ff), .mosi_ff(mosi_ff));

// *** tb/test_isp_host.sv ***
// Self-checking bench for the serial programming host
`timescale 1ns/10ps
`include "isp_consts.vh"
module test_isp_host;
  typedef struct {logic [3:0] op; logic [15:0] a; logic [7:0] d; logic poll; logic [7:0] exp;} row_t;
  localparam logic [7:0] SIG = 8'h5c; // Arbitrary identity value
  logic clk_sys = 1'b0, rst_b = 1'b0, session_en = 1'b0, use_poll = 1'b0, bad_echo = 1'b0;
  logic cmd_valid = 1'b0, rsp_ready = 1'b0, err, err2;
  logic [3:0] cmd_op = 4'h0;
  logic [15:0] cmd_addr = 16'h0000;
  logic [7:0] cmd_data = 8'h00;
  wire cmd_ready, cmd_err_ff, rsp_valid, prog_enabled_ff, sync_err_ff, busy;
  wire dev_rst_b_ff, sck_ff, mosi_ff, miso, in_prog;
  wire [7:0] rsp_data;
  wire [31:0] viol, n_pe;
  int errors = 0, n_tests = 0;
  row_t rows [21] = '{
    '{`OP_ERASE, 16'h0000, 8'h00, 1'b1, 8'h00}, '{`OP_RD_LO, 16'h0005, 8'h00, 1'b0, 8'hff},
    '{`OP_RD_EE, 16'h0003, 8'h00, 1'b0, 8'hff}, '{`OP_LD_LO, 16'h0045, 8'h11, 1'b0, 8'h00},
    '{`OP_LD_HI, 16'h0045, 8'h22, 1'b0, 8'h00}, '{`OP_WR_PAGE, 16'h0045, 8'h00, 1'b0, 8'h00},
    '{`OP_RD_LO, 16'h0045, 8'h00, 1'b0, 8'h11}, '{`OP_RD_HI, 16'h0045, 8'h00, 1'b0, 8'h22},
    '{`OP_RD_LO, 16'h0005, 8'h00, 1'b0, 8'hff}, '{`OP_WR_EE, 16'h0123, 8'h5a, 1'b1, 8'h00},
    '{`OP_RD_EE, 16'h0123, 8'h00, 1'b0, 8'h5a}, '{`OP_LD_EE, 16'h0121, 8'ha5, 1'b0, 8'h00},
    '{`OP_WR_EE_PG, 16'h0120, 8'h00, 1'b0, 8'h00}, '{`OP_RD_EE, 16'h0121, 8'h00, 1'b0, 8'ha5},
    '{`OP_RD_EE, 16'h0123, 8'h00, 1'b0, 8'h5a}, '{`OP_WR_FUSE, 16'h0000, 8'he2, 1'b1, 8'h00},
    '{`OP_RD_FUSE, 16'h0000, 8'h00, 1'b0, 8'he2}, '{`OP_WR_LOCK, 16'h0000, 8'hfc, 1'b0, 8'h00},
    '{`OP_RD_LOCK, 16'h0000, 8'h00, 1'b0, 8'hfc}, '{`OP_RD_SIG, 16'h0001, 8'h00, 1'b0, SIG + 8'h01},
    '{`OP_POLL, 16'h0000, 8'h00, 1'b0, 8'h00}};
  always #12.5 clk_sys = ~clk_sys;
  isp_host #(.DEV_KHZ(32'd16000), .PWRUP_CYC(32'd20), .WD_SHORT_CYC(32'd2000),
    .WD_LONG_CYC(32'd3000), .MAX_RETRY(4'h1)) uut (.clk_sys(clk_sys), .rst_b(rst_b),
    .session_en(session_en), .use_poll(use_poll), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_err_ff(cmd_err_ff),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data),
    .prog_enabled_ff(prog_enabled_ff), .sync_err_ff(sync_err_ff), .busy(busy),
    .dev_rst_b_ff(dev_rst_b_ff), .sck_ff(sck_ff), .mosi_ff(mosi_ff), .miso(miso));
  isp_dev_model #(.SIG_BASE(SIG)) dev (.dev_rst_b(dev_rst_b_ff), .sck(sck_ff), .mosi(mosi_ff),
    .bad_echo(bad_echo), .miso(miso), .in_prog(in_prog), .viol(viol), .n_pe(n_pe));
  // Compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Issue one command at a falling edge and wait until the host is idle again
  task automatic do_cmd(input logic [3:0] op, input logic [15:0] a, input logic [7:0] d,
    output logic e);
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    #5;
    while (cmd_ready !== 1'b1) begin
      @(negedge clk_sys);
      #5;
    end
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    e = cmd_err_ff;
    @(negedge clk_sys);
    e = e | cmd_err_ff;
    while (busy === 1'b1) @(negedge clk_sys);
  endtask
  // Wait for a response, compare it, then take it
  task automatic pop(input logic [7:0] exp);
    while (rsp_valid !== 1'b1) @(negedge clk_sys);
    check(rsp_data, exp, "read data");
    rsp_ready = 1'b1;
    @(negedge clk_sys);
    rsp_ready = 1'b0;
    @(negedge clk_sys);
  endtask
  // Watchdog
  initial begin
    repeat (60000) @(posedge clk_sys);
    errors++;
    summarize;
  end
  // Main sequence
  initial begin
    repeat (3) @(negedge clk_sys);
    check(dev_rst_b_ff, 1'b1, "reset pin in reset");
    check(sck_ff, 1'b0, "clock in reset");
    check(busy, 1'b0, "busy in reset");
    repeat (2) @(negedge clk_sys);
    rst_b = 1'b1;
    @(negedge clk_sys);
    session_en = 1'b1;
    while (prog_enabled_ff !== 1'b1) @(negedge clk_sys);
    check(n_pe[7:0], 8'd1, "enable frames");
    check(in_prog, 1'b1, "device enabled");
    $display("session start done");
    foreach (rows[i]) begin
      use_poll = rows[i].poll;
      do_cmd(rows[i].op, rows[i].a, rows[i].d, err);
      check(err, 1'b0, "refused");
      if (rows[i].op inside {`OP_POLL, `OP_RD_LO, `OP_RD_HI, `OP_RD_EE, `OP_RD_SIG,
        `OP_RD_FUSE, `OP_RD_LOCK}) pop(rows[i].exp);
      $display("row %0d done", i);
    end
    do_cmd(`OP_LD_HI, 16'h0007, 8'h33, err);
    check(err, 1'b1, "high before low");
    $display("order test done");
    do_cmd(`OP_RD_EE, 16'h0121, 8'h00, err);
    do_cmd(`OP_RD_EE, 16'h0123, 8'h00, err);
    fork
      do_cmd(`OP_RD_EE, 16'h0120, 8'h00, err2);
    join_none
    repeat (20) @(negedge clk_sys);
    check(cmd_ready, 1'b0, "full buffer stall");
    check(busy, 1'b0, "stalled while idle");
    pop(8'ha5);
    pop(8'h5a);
    pop(8'hff);
    wait fork;
    $display("buffer test done");
    session_en = 1'b0;
    repeat (4) @(negedge clk_sys);
    check(dev_rst_b_ff, 1'b1, "session end pin");
    check(in_prog, 1'b0, "device left programming");
    bad_echo = 1'b1;
    session_en = 1'b1;
    while (sync_err_ff !== 1'b1) @(negedge clk_sys);
    check(n_pe[7:0], 8'd3, "enable retries");
    check(prog_enabled_ff, 1'b0, "not enabled");
    do_cmd(`OP_RD_LO, 16'h0045, 8'h00, err);
    check(err, 1'b1, "refused unsynced");
    check(viol[7:0], 8'd0, "device misuse");
    $display("sync test done");
    summarize;
  end
endmodule // test_isp_host
